// File: src/mft_ctrl.v
// Download and upload control with transfer registers and file store
`timescale 1ns/1ps
`default_nettype none
`include "mft_consts.vh"
module mft_ctrl (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Register port from the command decoder
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	output reg [15:0] reg_rdata_r,
	output reg reg_ack_r,
	// Vendor poll setup
	input wire [2:0] poll_cfg,
	// Run request toward the module restart logic
	output reg run_req_r,
	output reg [3:0] run_sel_r
);
	// ==========================================================
	// States
	localparam ST_IDLE = 5'b00001;
	localparam ST_PREP = 5'b00010;
	localparam ST_XFER = 5'b00100;
	localparam ST_FIN = 5'b01000;
	localparam ST_END = 5'b10000;

	reg [4:0] st_r, st_nxt;
	reg [15:0] eac_r;
	reg [15:0] ea_r;
	reg [2:0] pol_r;
	reg start_ready_r, packet_ready_r, end_ready_r, valid_r, abort_request_flag_r;
	reg [3:0] type_r;
	reg [3:0] run_version_r;
	reg upload_r;
	reg [7:0] cnt_r;
	reg [15:0] sum_r;
	reg [15:0] words_r;

	wire ctrl_wr = reg_wr && (reg_addr == `MFT_OFF_CTRL);
	wire ear_wr = reg_wr && (reg_addr == `MFT_OFF_EAR);
	wire ear_rd = reg_rd && (reg_addr == `MFT_OFF_EAR);
	wire ear_acc = ear_wr || ear_rd;
	wire c_init = ctrl_wr && (reg_wdata[`MFT_C_INIT_WR] || reg_wdata[`MFT_C_INIT_RD]);
	wire c_abort = ctrl_wr && reg_wdata[`MFT_C_ABORT];
	wire c_done = ctrl_wr && reg_wdata[`MFT_C_DONE];
	wire [3:0] c_run_version = reg_wdata[`MFT_RUN_VERSION_LO+3:`MFT_RUN_VERSION_LO];
	wire [3:0] c_type = reg_wdata[`MFT_TYPE_LO+3:`MFT_TYPE_LO];

	// ==========================================================
	// Address stepping
	function [15:0] step_addr;
		input [15:0] a;
		input [1:0] mode;
		input [1:0] incr;
		begin
			case (mode)
				2'h1: step_addr = a + {14'h0000, incr};
				2'h2: step_addr = a - {14'h0000, incr};
				default: step_addr = a;
			endcase
		end
	endfunction

	// Location is high bits joined with low address; store is byte indexed in byte mode, word indexed otherwise
	wire [21:0] loc = {eac_r[5:0], ea_r};
	wire byte_mode = (eac_r[8:7] == 2'h1);
	wire [9:0] mem_addr = byte_mode ? loc[9:0] : loc[10:1];
	// Single-byte mode keeps the low byte only, zero above it
	wire [15:0] mem_wdata = byte_mode ? {8'h00, reg_wdata[7:0]} : reg_wdata;
	wire [15:0] mem_rdata;
	reg ear_rd_d_r;

	mft_mem u_mem (
		.clk(clk),
		.we(ear_wr && start_ready_r && !upload_r && st_r == ST_XFER),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata_r(mem_rdata)
	);

	// ==========================================================
	// Transfer state machine
	always @* begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (c_init) begin
					st_nxt = ST_PREP;
				end
			end
			ST_PREP: begin
				// With start polling off the host may finish before the preset settles
				if (c_done) begin
					st_nxt = ST_FIN;
				end else if (cnt_r == 8'h00) begin
					st_nxt = ST_XFER;
				end
			end
			ST_XFER: begin
				if (c_done) begin
					st_nxt = ST_FIN;
				end
			end
			ST_FIN: begin
				if (cnt_r == 8'h00) begin
					st_nxt = ST_END;
				end
			end
			ST_END: begin
				if (c_init) begin
					st_nxt = ST_PREP;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
		if (c_abort) begin
			st_nxt = ST_IDLE;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= ST_IDLE;
			cnt_r <= 8'h00;
			eac_r <= `MFT_EAC_RST;
			ea_r <= `MFT_EA_RST;
			pol_r <= `MFT_POL_RST;
			start_ready_r <= 1'b0;
			packet_ready_r <= 1'b0;
			end_ready_r <= 1'b0;
			valid_r <= 1'b0;
			abort_request_flag_r <= 1'b0;
			type_r <= 4'h0;
			upload_r <= 1'b0;
			sum_r <= 16'h0000;
			words_r <= 16'h0000;
			ear_rd_d_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			ear_rd_d_r <= ear_rd;
			if (cnt_r != 8'h00) begin
				cnt_r <= cnt_r - 8'h01;
			end
			if (reg_wr && reg_addr == `MFT_OFF_EAC) begin
				eac_r <= reg_wdata;
			end
			if (reg_wr && reg_addr == `MFT_OFF_EA) begin
				ea_r <= reg_wdata;
			end
			// Host reads and writes of the data register in the transfer state step the address after the access
			if (ear_acc && st_r == ST_XFER) begin
				ea_r <= step_addr(ea_r, ear_wr ? eac_r[13:12] : eac_r[15:14],
					eac_r[8:7]);
				words_r <= words_r + 16'h0001;
				if (ear_wr) begin
					sum_r <= sum_r + mem_wdata;
				end
				if (pol_r[1]) begin
					packet_ready_r <= 1'b0;
					cnt_r <= `MFT_PKT_CYC;
				end
			end else if (st_r == ST_XFER && pol_r[1] && cnt_r == 8'h00) begin
				packet_ready_r <= 1'b1;
			end
			if (c_init) begin
				pol_r <= poll_cfg;
				eac_r <= reg_wdata[`MFT_C_INIT_WR] ? `MFT_EAC_DL : `MFT_EAC_UL;
				ea_r <= `MFT_EA_RST;
				upload_r <= !reg_wdata[`MFT_C_INIT_WR];
				type_r <= c_type;
				cnt_r <= `MFT_PREP_CYC;
				start_ready_r <= !poll_cfg[0];
				packet_ready_r <= !poll_cfg[1];
				end_ready_r <= !poll_cfg[2];
				valid_r <= 1'b0;
				sum_r <= 16'h0000;
				words_r <= 16'h0000;
			end
			if (st_r == ST_PREP && cnt_r == 8'h00) begin
				start_ready_r <= 1'b1;
			end
			if (c_done && (st_r == ST_XFER || st_r == ST_PREP)) begin
				cnt_r <= `MFT_FIN_CYC;
			end
			if (st_r == ST_FIN && cnt_r == 8'h00) begin
				end_ready_r <= 1'b1;
				// Consistency: a code type is named and, for a download, something moved
				if (type_r != 4'h0 && (upload_r || words_r != 16'h0000)) begin
					valid_r <= 1'b1;
				end else begin
					abort_request_flag_r <= 1'b1;
				end
			end
			if (c_abort) begin
				abort_request_flag_r <= 1'b0;
				start_ready_r <= 1'b0;
				packet_ready_r <= 1'b0;
				end_ready_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Running version, set back to MFT_RUN_VERSION_RST by reset of this block
	reg [3:0] run_version_keep_r;
	reg run_version_seen_r;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run_req_r <= 1'b0;
			run_sel_r <= 4'h0;
			run_version_r <= `MFT_RUN_VERSION_RST;
			run_version_seen_r <= 1'b0;
			run_version_keep_r <= 4'h0;
		end else begin
			run_req_r <= 1'b0;
			if (!run_version_seen_r) begin
				run_version_seen_r <= 1'b1;
				run_version_r <= `MFT_RUN_VERSION_RST;
			end
			// Request the switch in the same cycle as the acknowledge
			if (ctrl_wr && c_run_version != 4'h0 && !c_abort) begin
				run_req_r <= 1'b1;
				run_sel_r <= c_run_version;
				run_version_keep_r <= c_run_version;
				if (c_run_version != `MFT_RUN_VERSION_LATEST) begin
					run_version_r <= c_run_version;
				end
			end
		end
	end

	// ==========================================================
	// Register read and acknowledge
	wire [15:0] stat_word = {abort_request_flag_r, valid_r, 7'h00, end_ready_r,
		(pol_r[1] ? packet_ready_r : 1'b1), start_ready_r, 1'b0, pol_r};
	wire [15:0] ctrl_word = {4'h0, run_version_r, 8'h00};

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_r <= 16'h0000;
			reg_ack_r <= 1'b0;
		end else begin
			reg_ack_r <= reg_wr || reg_rd;
			if (reg_rd) begin
				case (reg_addr)
					`MFT_OFF_CTRL: reg_rdata_r <= ctrl_word;
					`MFT_OFF_STAT: reg_rdata_r <= stat_word;
					`MFT_OFF_EAC: reg_rdata_r <= eac_r;
					`MFT_OFF_EA: reg_rdata_r <= ea_r;
					default: reg_rdata_r <= 16'h0000;
				endcase
			end else if (ear_rd_d_r) begin
				reg_rdata_r <= mem_rdata;
			end
		end
	end
endmodule // mft_ctrl
`default_nettype wire

// File: pkg/mft_consts.vh
// Constants for the module file transfer control block
`ifndef MFT_CONSTS_VH
`define MFT_CONSTS_VH
`define MFT_OFF_EAC 8'h0E
`define MFT_OFF_EA 8'h0F
`define MFT_OFF_EAR 8'h10
`define MFT_OFF_CTRL 8'h14
`define MFT_OFF_STAT 8'h15
`define MFT_C_INIT_WR 0
`define MFT_C_ABORT 1
`define MFT_C_DONE 2
`define MFT_C_INIT_RD 3
`define MFT_RUN_VERSION_LO 8
`define MFT_TYPE_LO 12
`define MFT_S_START_POLL_REQUIRED 0
`define MFT_S_PACKET_POLL_REQUIRED 1
`define MFT_S_END_POLL_REQUIRED 2
`define MFT_S_START_READY 4
`define MFT_S_PACKET_READY 5
`define MFT_S_END_READY 6
`define MFT_S_VALID 14
`define MFT_S_ABORT_REQUEST_FLAG 15
`define MFT_RUN_VERSION_LATEST 4'hF
`define MFT_RUN_VERSION_RST 4'h3
`define MFT_EAC_RST 16'h0000
`define MFT_EAC_DL 16'h1080
`define MFT_EAC_UL 16'h4080
`define MFT_EA_RST 16'h0000
`define MFT_POL_RST 3'h7
`define MFT_PREP_NS 100
`define MFT_PREP_CYC 4
`define MFT_PKT_CYC 2
`define MFT_FIN_CYC 8
`define MFT_MEM_AW 10
`endif

// File: src/mft_mem.v
// Small synchronous word memory holding the transferred file
`timescale 1ns/1ps
`default_nettype none
module mft_mem (
	// Clock
	input wire clk,
	// Access port
	input wire we,
	input wire [9:0] addr,
	input wire [15:0] wdata,
	output reg [15:0] rdata_r
);
	reg [15:0] mem [0:1023];
	always @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata_r <= mem[addr];
	end
endmodule // mft_mem
`default_nettype wire

// File: test/mft_ctrl_assertions.sv
// Checker of register handshake, readback and run request
`timescale 1ns/1ps
`default_nettype none
module mft_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port and poll setup
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata_r,
	input wire logic reg_ack_r,
	input wire logic [2:0] poll_cfg,
	// Run request
	input wire logic run_req_r,
	input wire logic [3:0] run_sel_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [3:0] run_version_r;
	logic run_wr, stat_rd, ctrl_rd, map;
	assign run_wr = reg_wr && reg_addr == 8'h14 && reg_wdata[11:8] != 4'h0;
	assign stat_rd = reg_rd && reg_addr == 8'h15;
	assign ctrl_rd = reg_rd && reg_addr == 8'h14;
	assign map = reg_addr inside {8'h0E, 8'h0F, 8'h10, 8'h14, 8'h15};
	// Last version asked for by the host
	always @(posedge clk or negedge rstn) begin
		if (!rstn) run_version_r <= 4'h0;
		else if (run_wr && !reg_wdata[1]) run_version_r <= reg_wdata[11:8];
	end
	a_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack_r) else $error("ack missing");
	a_ack_cause: assert property (reg_ack_r |-> $past(reg_wr || reg_rd)) else $error("stray ack");
	a_run_req_due: assert property ((run_wr && reg_wdata[3:0] == 4'h0) |-> ##[1:3] run_req_r) else $error("no run");
	a_run_sel_match: assert property (run_req_r |-> run_sel_r == run_version_r) else $error("bad run sel");
	a_run_pulse: assert property (run_req_r |=> !run_req_r) else $error("run not a pulse");
	a_ctrl_read: assert property (ctrl_rd |=> reg_rdata_r[15:12] == 4'h0 && reg_rdata_r[7:0] == 8'h00) else $error("ctrl field");
	a_stat_unused: assert property (stat_rd |=> reg_rdata_r[13:7] == 7'h00 && !reg_rdata_r[3]) else $error("stat bits");
	a_unmapped_zero: assert property ((reg_rd && !map) |=> reg_rdata_r == 16'h0000) else $error("unmapped");
	c_run: cover property (run_req_r);
	c_data_wr: cover property (reg_wr && reg_addr == 8'h10);
	c_end_seen: cover property (stat_rd ##1 reg_rdata_r[6]);
endmodule // mft_chk
bind mft_ctrl mft_chk u_chk (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .reg_ack_r(reg_ack_r),
	.poll_cfg(poll_cfg), .run_req_r(run_req_r), .run_sel_r(run_sel_r));
`default_nettype wire

// File: test/mft_host.sv
// Host model issuing register accesses and status polls
`timescale 1ns/1ps
`default_nettype none
module mft_host (
	// Clock
	input wire logic clk,
	// Register port toward the block
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata_r,
	input wire logic reg_ack_r
);
	int n_late = 0;
	logic [15:0] q;
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
	end
	// One strobe; data register reads answer a cycle after the ack
	task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_wdata <= ~d;
		#1;
		if (reg_ack_r !== 1'b1) n_late++;
		if (!w && a == 8'h10) @(posedge clk);
		#1;
		q = reg_rdata_r;
	endtask
	// Status is read until the bit is set, giving up after a bound
	task poll(input int b);
		int i;
		for (i = 0; i < 40; i++) begin
			acc(1'b0, 8'h15, 16'h0000);
			if (q[b] === 1'b1) break;
		end
		if (i == 40) n_late++;
	endtask
endmodule // mft_host
`default_nettype wire

// File: test/tb_top.sv
// Top testbench for the module file transfer control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb_top;
	logic clk, rstn, reg_wr, reg_rd, reg_ack_r, run_req_r;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata_r;
	logic [2:0] poll_cfg;
	logic [3:0] run_sel_r;
	int n_mismatch = 0;
	int checks_done = 0;
	mft_ctrl dut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .reg_ack_r(reg_ack_r),
		.poll_cfg(poll_cfg), .run_req_r(run_req_r), .run_sel_r(run_sel_r));
	mft_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .reg_ack_r(reg_ack_r));
	task summarize;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task w(input logic [7:0] a, input logic [15:0] d);
		host.acc(1'b1, a, d);
	endtask
	task rm(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		host.acc(1'b0, a, 16'h0000);
		`CHK(host.q & m, e)
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		rstn = 1'b0;
		poll_cfg = 3'h7;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rm(8'h15, 16'hFFFF, 16'h0007);
		rm(8'h14, 16'hFFFF, 16'h0300);
		rm(8'h20, 16'hFFFF, 16'h0000);
		// Download of two bytes in byte mode, all stages polled
		w(8'h14, 16'h1001);
		rm(8'h0E, 16'hFFFF, 16'h1080);
		rm(8'h0F, 16'hFFFF, 16'h0000);
		host.poll(4);
		w(8'h10, 16'h00AB);
		host.poll(5);
		w(8'h10, 16'h00CD);
		host.poll(5);
		w(8'h14, 16'h1004);
		host.poll(6);
		rm(8'h15, 16'hC007, 16'h4007);
		// Upload of the same bytes, packet polling off
		@(posedge clk);
		poll_cfg <= 3'h5;
		w(8'h14, 16'h1008);
		rm(8'h0E, 16'hFFFF, 16'h4080);
		host.poll(4);
		rm(8'h10, 16'hFFFF, 16'h00AB);
		host.poll(5);
		rm(8'h10, 16'hFFFF, 16'h00CD);
		host.poll(5);
		w(8'h14, 16'h1004);
		host.poll(6);
		// Empty download without polling fails and is aborted
		@(posedge clk);
		poll_cfg <= 3'h0;
		w(8'h14, 16'h2001);
		rm(8'h15, 16'h0077, 16'h0070);
		w(8'h14, 16'h2004);
		repeat (10) @(posedge clk);
		rm(8'h15, 16'hC000, 16'h8000);
		w(8'h14, 16'h0002);
		rm(8'h15, 16'hC070, 16'h0020);
		// Version selection
		w(8'h14, 16'h0100);
		rm(8'h14, 16'hFFFF, 16'h0100);
		w(8'h14, 16'h0F00);
		rm(8'h14, 16'hFFFF, 16'h0100);
		`CHK(host.n_late, 0)
		summarize;
	end
endmodule // tb_top
`default_nettype wire
